// file: design/cis_chan_or.sv
// Per-channel OR of pending, unmasked interrupt sources
`timescale 1ns/1ps
module cis_chan_or
  import cis_pkg::*;
#(
  parameter int NCH = 13,
  parameter int NSRC = 4
) (
  input  wire logic [NCH*NSRC-1:0] src_pend,
  input  wire logic [NCH*NSRC-1:0] src_en,
  output logic      [NCH-1:0]      chan_flag
);
  // One flag per channel clears by itself once all sources clear
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chan_flag[c] = |(src_pend[c*NSRC +: NSRC] &
                       src_en[c*NSRC +: NSRC]);
    end
  end
endmodule // cis_chan_or

// file: design/cis_pkg.sv
// Package of constants for the channel interrupt summary block
// Overview of operation
// - Summary reg 3 bits 7..0 report channels 24 down to 17.
// - Channel flag reads 1 while any enabled interrupt of channel is pending.
// - Summary reg 4 bits 3..0 report channels 28 down to 25.
// - Summary reg 4 bit 7 reports extra channel 0; bits 6..4 reserved.
// - Second tick status is meaningful only while its mask bit is 0.
// - Second tick expiry sets status only while gcfg bit 0 is 0; it raises the interrupt pin only if imask bit 0 is also 1.
// - Writing 1 clears second tick status; reset value is 0.
package cis_pkg;
  localparam logic [11:0] CIS_OFF_SUM3   = 12'h340;
  localparam logic [11:0] CIS_OFF_SUM4   = 12'h380;
  localparam logic [11:0] CIS_OFF_TICK   = 12'h3c0;
  localparam logic [11:0] CIS_OFF_GCFG   = 12'h3c4;
  localparam logic [11:0] CIS_OFF_ISTAT  = 12'h3c8;
  localparam logic [11:0] CIS_OFF_IMASK  = 12'h3cc;
  localparam int          CIS_CH_N       = 12;
  localparam int          CIS_SUM3_LO    = 17;
  localparam int          CIS_SUM4_LO    = 25;
  localparam int          CIS_SUM4_N     = 4;
  localparam int          CIS_XCH_BIT    = 7;
  localparam int          CIS_TICK_BIT   = 0;
  localparam int          CIS_TMASK_BIT  = 0;
  localparam logic [7:0]  CIS_RST_SUM    = 8'h00;
  localparam logic [7:0]  CIS_RST_GCFG   = 8'h00;
  localparam logic [7:0]  CIS_RST_IMASK  = 8'h00;
  localparam int          CIS_EV_N       = 2;
  localparam int          CIS_EV_TICK    = 0;
  localparam int          CIS_EV_CHAN    = 1;
  localparam int          CIS_CLK_MHZ    = 100;
  localparam int          CIS_SEC_MS     = 1000;
  localparam int          CIS_SEC_CYC    = CIS_SEC_MS * 1000 * CIS_CLK_MHZ;
endpackage

// file: design/cis_top.sv
// Channel interrupt summary registers and second tick status, APB slave
`timescale 1ns/1ps
module cis_top
  import cis_pkg::*;
#(
  parameter int NSRC    = 4,
  parameter int SEC_CYC = CIS_SEC_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [13*NSRC-1:0]     src_pend,
  input  wire logic [13*NSRC-1:0]     src_en,
  output logic                        irq
);
  localparam int NCH = CIS_CH_N + 1;

  typedef struct packed {
    logic [7:0]  sum3;
    logic [7:0]  sum4;
    logic        tick_sts;
    logic [7:0]  gcfg;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic [31:0] sec_cnt;
    logic        any_chan;
    logic [31:0] rdata;
  } cis_state_s;

  cis_state_s s_q, s_d;
  logic [NCH-1:0] chan_flag;
  logic           acc;
  logic           wr;
  logic           rd;
  logic           hit;
  logic           tick;
  logic           chan_rise;
  logic           clr_tick;
  logic [7:0]     sum3_n;
  logic [7:0]     sum4_n;

  // Map address to the decode hit
  function automatic logic addr_hit(input logic [11:0] a);
    return a == CIS_OFF_SUM3 || a == CIS_OFF_SUM4 || a == CIS_OFF_TICK ||
           a == CIS_OFF_GCFG || a == CIS_OFF_ISTAT || a == CIS_OFF_IMASK;
  endfunction

  // Bit b of lane 0, only when that byte lane is written
  function automatic logic wbit(input logic [31:0] d, input logic [3:0] st,
                                input int b);
    return st[0] & d[b];
  endfunction

  // Channels 17..28 at indices 0..11 plus extra channel 0 at index 12
  cis_chan_or #(
    .NCH  (NCH),
    .NSRC (NSRC)
  ) u_or (
    .src_pend  (src_pend),
    .src_en    (src_en),
    .chan_flag (chan_flag)
  );

  // Bus phases; answer in the access cycle, no wait states
  assign acc      = psel & penable & clk_en;
  assign wr       = acc & pwrite;
  assign rd       = psel & ~penable & ~pwrite & clk_en;
  assign hit      = addr_hit(paddr);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = s_q.rdata;
  assign tick     = (s_q.sec_cnt == 32'(SEC_CYC - 1));
  assign clr_tick = wr && paddr == CIS_OFF_TICK &&
                    wbit(pwdata, pstrb, CIS_TICK_BIT);

  // Pack channel flags into the two summary layouts
  always_comb begin
    sum3_n = chan_flag[7:0];
    sum4_n = 8'h00; // reserved bits read 0
    sum4_n[CIS_SUM4_N-1:0] = chan_flag[11:8];
    sum4_n[CIS_XCH_BIT] = chan_flag[12];
  end
  assign chan_rise = (|chan_flag) & ~s_q.any_chan;

  // Next state; the set of a sticky bit wins over a same-cycle clear
  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      s_d.sum3 = sum3_n;
      s_d.sum4 = sum4_n;
      s_d.any_chan = |chan_flag;
      s_d.sec_cnt = tick ? 32'h0 : s_q.sec_cnt + 32'h1;
      if (clr_tick) s_d.tick_sts = 1'b0;
      // Expiry is only flagged while unmasked in the config register
      if (tick && !s_q.gcfg[CIS_TMASK_BIT]) s_d.tick_sts = 1'b1;
      if (wr && paddr == CIS_OFF_GCFG && pstrb[0]) s_d.gcfg = pwdata[7:0];
      if (wr && paddr == CIS_OFF_IMASK && pstrb[0])
        s_d.imask = pwdata[CIS_EV_N-1:0];
      if (wr && paddr == CIS_OFF_ISTAT && pstrb[0])
        s_d.istat = s_q.istat & ~pwdata[CIS_EV_N-1:0];
      if (tick && !s_q.gcfg[CIS_TMASK_BIT]) s_d.istat[CIS_EV_TICK] = 1'b1;
      if (chan_rise) s_d.istat[CIS_EV_CHAN] = 1'b1;
      // Read data is captured in setup so it is a flop in access
      if (rd) begin
        case (paddr)
          CIS_OFF_SUM3:  s_d.rdata = {24'h0, s_q.sum3};
          CIS_OFF_SUM4:  s_d.rdata = {24'h0, s_q.sum4};
          CIS_OFF_TICK:  s_d.rdata = {31'h0, s_q.tick_sts};
          CIS_OFF_GCFG:  s_d.rdata = {24'h0, s_q.gcfg};
          CIS_OFF_ISTAT: s_d.rdata = {30'h0, s_q.istat};
          CIS_OFF_IMASK: s_d.rdata = {30'h0, s_q.imask};
          default:       s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{sum3: CIS_RST_SUM, sum4: CIS_RST_SUM, tick_sts: 1'b0,
               gcfg: CIS_RST_GCFG, istat: 2'h0, imask: 2'h0,
               sec_cnt: 32'h0, any_chan: 1'b0, rdata: 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Level interrupt while an unmasked sticky bit stands
  assign irq = |(s_q.istat & s_q.imask);

  a_sum3_map: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> s_q.sum3 == $past(chan_flag[7:0]))
    else $error("summary 3 mismatch");
  a_sum4_map: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> s_q.sum4[3:0] == $past(chan_flag[11:8]))
    else $error("summary 4 low mismatch");
  // Reserved bits and the extra channel bit checked together
  a_sum4_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (s_q.sum4[6:4] == 3'h0 &&
                s_q.sum4[7] == $past(chan_flag[12])))
    else $error("summary 4 high bits wrong");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && chan_flag == '0) |=> (s_q.sum3 == 8'h0 && s_q.sum4 == 8'h0))
    else $error("flag stays with no pending");
  a_flag_or: assert property (@(posedge pclk) disable iff (!presetn)
    chan_flag[0] == |(src_pend[NSRC-1:0] & src_en[NSRC-1:0]))
    else $error("channel OR wrong");
  a_tick_set: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && tick && !s_q.gcfg[0]) |=> s_q.tick_sts ##1 1'b1)
    else $error("tick status not set");
  // A masked expiry must not raise a status bit that was clear
  a_tick_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && tick && s_q.gcfg[0] && !s_q.tick_sts) |=> !s_q.tick_sts)
    else $error("masked tick set status");
  a_tick_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_tick && !tick) |=> !s_q.tick_sts)
    else $error("tick status not cleared");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.istat[0]) && s_q.imask[0] |-> irq)
    else $error("irq missing");

  // Config and mask writes land at the access edge
  a_gcfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CIS_OFF_GCFG && pstrb[0])
      |=> s_q.gcfg == $past(pwdata[7:0]))
    else $error("config write lost");
  a_imask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CIS_OFF_IMASK && pstrb[0])
      |=> s_q.imask == $past(pwdata[1:0]))
    else $error("mask write lost");
  // Write one clears the channel event unless a new rise arrives
  a_istat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CIS_OFF_ISTAT && pstrb[0] && pwdata[1] && !chan_rise)
      |=> !s_q.istat[1])
    else $error("event status not cleared");
  a_chan_event: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && chan_rise) |=> s_q.istat[1])
    else $error("channel event lost");
  // Frozen clock enable keeps every state bit
  a_enable_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> s_q == $past(s_q))
    else $error("state moved while frozen");
  // Second counter wraps at the period end and steps otherwise
  a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && tick) |=> s_q.sec_cnt == 32'h0)
    else $error("second counter did not wrap");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !tick) |=> s_q.sec_cnt == $past(s_q.sec_cnt) + 32'h1)
    else $error("second counter did not step");
  // Read data is taken in setup and stands through access
  a_read_sum3: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == CIS_OFF_SUM3) |=> prdata == {24'h0, $past(s_q.sum3)})
    else $error("summary 3 read wrong");
  a_read_unmap: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && !hit) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_err_unmap: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !hit) |-> pslverr)
    else $error("unmapped access not refused");

  c_tick: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.tick_sts));
  c_clear: cover property (@(posedge pclk) disable iff (!presetn)
    clr_tick && s_q.tick_sts);
  c_chan: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.sum4[7]));
endmodule // cis_top

// file: verification/tb_cis_top.sv
// Self-checking testbench for the channel interrupt summary block
`timescale 1ns/1ps
module tb_cis_top;
  import cis_pkg::*;
  localparam int NS  = 4;
  localparam int SEC = 20;
  logic              pclk     = 1'b0;
  logic              presetn  = 1'b0;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [11:0]       paddr    = 12'h000;
  logic [31:0]       pwdata   = 32'h0;
  logic [13*NS-1:0]  src_pend = '0;
  logic [13*NS-1:0]  src_en   = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [31:0]       rd;
  logic              er;
  int                num_errors = 0;
  int                num_checks = 0;
  int                seed       = 25407;

  cis_top #(.NSRC(NS), .SEC_CYC(SEC)) cis_top_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_pend(src_pend), .src_en(src_en), .irq(irq));

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(logic [11:0] a, logic [31:0] e, string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // Flag per channel is OR of its pending and enabled sources
  function automatic logic [15:0] expsum(logic [13*NS-1:0] p,
                                         logic [13*NS-1:0] e);
    logic [12:0] f;
    for (int c = 0; c < 13; c++) f[c] = |(p[c*NS+:NS] & e[c*NS+:NS]);
    return {f[12], 3'h0, f[11:8], f[7:0]};
  endfunction

  initial begin
    int i;
    logic [63:0] r1, r2;
    logic [15:0] ex;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(CIS_OFF_SUM3, 32'h0, "sum3 reset");
    rdchk(CIS_OFF_SUM4, 32'h0, "sum4 reset");
    // Unmask tick event, clear stale status, wait for the pin
    apb(1'b1, CIS_OFF_IMASK, 32'h1);
    apb(1'b1, CIS_OFF_TICK, 32'h1);
    apb(1'b1, CIS_OFF_ISTAT, 32'h3);
    for (i = 0; i < 3 * SEC && irq !== 1'b1; i++) @(posedge pclk);
    chk("irq tick", 32'h1, {31'h0, irq});
    if (i == 3 * SEC) summarize();
    rdchk(CIS_OFF_TICK, 32'h1, "tick set");
    // Mask first so no new expiry races the clear and its read back
    apb(1'b1, CIS_OFF_GCFG, 32'h1);
    apb(1'b1, CIS_OFF_TICK, 32'h1);
    rdchk(CIS_OFF_TICK, 32'h0, "tick clear");
    // Masked tick must leave status and pin quiet over several periods
    apb(1'b1, CIS_OFF_ISTAT, 32'h3);
    repeat (3 * SEC) @(posedge pclk);
    rdchk(CIS_OFF_TICK, 32'h0, "tick masked");
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, CIS_OFF_GCFG, 32'h0);
    // Unmapped place is refused and reads zero
    apb(1'b1, 12'h3d0, 32'hff);
    chk("slverr wr", 32'h1, {31'h0, er});
    rdchk(12'h3d0, 32'h0, "unmapped");
    // Corners first: all set, all disabled, none pending, then random mixes
    for (int k = 0; k < 24; k++) begin
      r1 = k == 0 ? '1 : k == 2 ? '0 : {$random(seed), $random(seed)};
      r2 = k == 1 ? '0 : k == 0 ? '1 : {$random(seed), $random(seed)};
      @(posedge pclk);
      src_pend <= r1[13*NS-1:0];
      src_en <= r2[13*NS-1:0];
      ex = expsum(r1[13*NS-1:0], r2[13*NS-1:0]);
      rdchk(CIS_OFF_SUM3, {24'h0, ex[7:0]}, "sum3");
      rdchk(CIS_OFF_SUM4, {24'h0, ex[15:8]}, "sum4");
    end
    // Channel event: masked, unmasked, then cleared
    apb(1'b1, CIS_OFF_IMASK, 32'h0);
    @(posedge pclk);
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, CIS_OFF_IMASK, 32'h2);
    @(posedge pclk);
    chk("irq chan", 32'h1, {31'h0, irq});
    apb(1'b1, CIS_OFF_ISTAT, 32'h3);
    @(posedge pclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    summarize();
  end
endmodule // tb_cis_top
